/* hdl/smc_consts.vh */
// constants for the stepper slave protection and bridge block
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
// register byte offsets
`define SMC_REG_CTRL 8'h00
`define SMC_REG_FRAME 8'h04
`define SMC_REG_STATUS 8'h08
`define SMC_REG_IRQ_STAT 8'h0c
`define SMC_REG_IRQ_MASK 8'h10
`define SMC_REG_BRIDGE 8'h14
`define SMC_REG_ADDR 8'h18
// ctrl fields
`define SMC_CTRL_DIR 0
`define SMC_CTRL_GATE 1
`define SMC_CTRL_EN 2
`define SMC_CTRL_PROG 3
// frame fields: data bits 4:0, select bits 7:5
`define SMC_FR_TOP 4
`define SMC_FR_SEL_LO 5
`define SMC_FR_SEL_HI 7
// status codes
`define SMC_CODE_IDLE 3'h0
`define SMC_CODE_ACTIVE 3'h6
`define SMC_CODE_OK 3'h4
`define SMC_CODE_BEMF 3'h1
`define SMC_CODE_ABORT 3'h2
// interrupt bits
`define SMC_IRQ_ACTIVE 0
`define SMC_IRQ_OK 1
`define SMC_IRQ_BEMF 2
`define SMC_IRQ_ABORT 3
`define SMC_IRQ_W 4
// timing in microseconds, clock 100 MHz
`define SMC_CLK_MHZ 100
`define SMC_T_PULL_US 150
`define SMC_T_DELAY_US 275
`define SMC_T_VIOL_US 75
`define SMC_T_ENERGISE_US 500
// counter width
`define SMC_CNT_W 16
`endif

/* hdl/smc_bridge.v */
// h-bridge gate decode and back-emf sense for one coil
`timescale 1ns/1ps
module smc_bridge (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire dir,
	input wire gate,
	input wire en,
	// synchronised sense inputs
	input wire sense_hi,
	input wire sense_lo,
	// gates: q1 upper a1, q2 upper a2-side, q3/q4 lower
	output reg [3:0] gates_q,
	output reg bemf_pulse_q
);
	reg [3:0] gates_d;
	reg prev_or_q;
	wire sense_or = sense_hi | sense_lo;
	always @* begin
		// dir 0: q2 and q4, current a2 to a1
		if (!dir)
			gates_d = 4'ha;
		else
			gates_d = 4'h5;
		if (!en)
			gates_d = gates_d & 4'h3;
		if (!gate)
			gates_d = 4'h0;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			gates_q <= 4'h0;
			prev_or_q <= 1'b0;
			bemf_pulse_q <= 1'b0;
		end else begin
			gates_q <= gates_d;
			prev_or_q <= sense_or;
			// rising edge of sense_or (either sense transistor, while the other is low), any decay case
			bemf_pulse_q <= sense_or & ~prev_or_q;
		end
	end
endmodule // smc_bridge

/* hdl/smc_top.v */
// stepper slave: protection programming handshake and bridge control over apb
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_top #(
	parameter [2:0] SLAVE_SEL = 3'h0,
	parameter CNT_W = `SMC_CNT_W
) (
	// clock and reset
	input wire CLK,
	input wire RST,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// pins
	input wire PROG_LEVEL,
	input wire SENSE_HI,
	input wire SENSE_LO,
	// outputs
	output reg [3:0] BRIDGE_GATES,
	output reg CELL_ENERGISE,
	output reg [2:0] RETURN_STATUS,
	output reg RETURN_VALID,
	output reg IRQ
);
	localparam [CNT_W-1:0] PULL_CYC = `SMC_T_PULL_US * `SMC_CLK_MHZ;
	localparam [CNT_W-1:0] ENERGISE_CYC = `SMC_T_ENERGISE_US * `SMC_CLK_MHZ;
	localparam [CNT_W-1:0] SPAN_CYC = (`SMC_T_PULL_US + `SMC_T_DELAY_US
		+ `SMC_T_VIOL_US) * `SMC_CLK_MHZ;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ARMED = 2'h1;
	localparam [1:0] ST_ENERGISE = 2'h2;
	localparam [1:0] ST_DONE = 2'h3;

	function is_addr;
		input [7:0] a;
		input [7:0] off;
		begin
			is_addr = (a == off);
		end
	endfunction

	// pin synchronisers
	reg [1:0] prog_sync_q;
	reg [1:0] hi_sync_q;
	reg [1:0] lo_sync_q;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			prog_sync_q <= 2'b00;
			hi_sync_q <= 2'b00;
			lo_sync_q <= 2'b00;
		end else begin
			prog_sync_q <= {prog_sync_q[0], PROG_LEVEL};
			hi_sync_q <= {hi_sync_q[0], SENSE_HI};
			lo_sync_q <= {lo_sync_q[0], SENSE_LO};
		end
	end
	wire prog_level = prog_sync_q[1];

	// registers
	reg [3:0] ctrl_q;
	reg [7:0] frame_q;
	reg frame_go_q;
	reg [`SMC_IRQ_W-1:0] irq_stat_q;
	reg [`SMC_IRQ_W-1:0] irq_mask_q;
	reg [1:0] state_q;
	reg [CNT_W-1:0] cnt_q;
	reg protected_q;
	reg bemf_seen_q;
	reg [2:0] status_q;

	wire coil_a_direction_bit = ctrl_q[`SMC_CTRL_DIR];
	wire coil_a_drive_gate = ctrl_q[`SMC_CTRL_GATE];
	wire coil_en = ctrl_q[`SMC_CTRL_EN];
	wire [3:0] gates;
	wire bemf_pulse;

	smc_bridge u_bridge (
		.clk(CLK),
		.rst(RST),
		.dir(coil_a_direction_bit),
		.gate(coil_a_drive_gate),
		.en(coil_en),
		.sense_hi(hi_sync_q[1]),
		.sense_lo(lo_sync_q[1]),
		.gates_q(gates),
		.bemf_pulse_q(bemf_pulse)
	);

	// apb decode; single-cycle access phase, pready registered high only in the cycle after setup
	wire acc = PSEL & PENABLE;
	wire wr = acc & PWRITE;
	wire rd_ok = is_addr(PADDR, `SMC_REG_CTRL) | is_addr(PADDR, `SMC_REG_FRAME)
		| is_addr(PADDR, `SMC_REG_STATUS) | is_addr(PADDR, `SMC_REG_IRQ_STAT)
		| is_addr(PADDR, `SMC_REG_IRQ_MASK) | is_addr(PADDR, `SMC_REG_BRIDGE)
		| is_addr(PADDR, `SMC_REG_ADDR);

	// a frame decodes when software writes the frame register
	wire [7:0] fr = PWDATA[7:0];
	wire frame_wr = wr & is_addr(PADDR, `SMC_REG_FRAME);
	wire sel_match = (fr[`SMC_FR_SEL_HI:`SMC_FR_SEL_LO] == SLAVE_SEL);
	wire protect_instr = (fr[`SMC_FR_TOP-1:0] == 4'h0) & fr[`SMC_FR_TOP];
	wire frame_addressed = frame_wr & sel_match;

	// protection sequencer
	reg [1:0] state_d;
	reg [CNT_W-1:0] cnt_d;
	reg protected_d;
	reg abort;
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		protected_d = protected_q;
		abort = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// only instructions seen at programming level count
				if (frame_addressed & protect_instr & prog_level)
					state_d = ST_ARMED;
			end
			ST_ARMED: begin
				if (!prog_level) begin
					state_d = ST_IDLE;
					abort = 1'b1;
				end else if (frame_addressed & protect_instr) begin
					state_d = ST_ENERGISE;
					cnt_d = {CNT_W{1'b0}};
				end
			end
			ST_ENERGISE: begin
				// level dropped mid-energise: cell left unprogrammed
				if (!prog_level) begin
					state_d = ST_IDLE;
					abort = 1'b1;
				end else if (cnt_q == ENERGISE_CYC - 1'b1) begin
					state_d = ST_DONE;
					protected_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			ST_DONE: begin
				// repeated instruction re-arms but protection stays
				if (frame_addressed & protect_instr & prog_level)
					state_d = ST_ARMED;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// current status code
	wire pull_window = (state_q == ST_ENERGISE) & (cnt_q < PULL_CYC);
	reg [2:0] code;
	always @* begin
		if (state_q == ST_ENERGISE)
			code = `SMC_CODE_ACTIVE;
		else if (protected_q)
			code = `SMC_CODE_OK;
		else if (bemf_seen_q)
			code = `SMC_CODE_BEMF;
		else
			code = `SMC_CODE_IDLE;
	end

	// interrupt events
	wire [`SMC_IRQ_W-1:0] ev;
	assign ev[`SMC_IRQ_ACTIVE] = pull_window & (cnt_q == {CNT_W{1'b0}});
	assign ev[`SMC_IRQ_OK] = (state_q == ST_ENERGISE) & (state_d == ST_DONE);
	assign ev[`SMC_IRQ_BEMF] = bemf_pulse;
	assign ev[`SMC_IRQ_ABORT] = abort;

	wire [`SMC_IRQ_W-1:0] clr = (wr & is_addr(PADDR, `SMC_REG_IRQ_STAT)) ?
		PWDATA[`SMC_IRQ_W-1:0] : {`SMC_IRQ_W{1'b0}};

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= 4'h0;
			frame_q <= 8'h00;
			frame_go_q <= 1'b0;
			irq_mask_q <= {`SMC_IRQ_W{1'b0}};
			irq_stat_q <= {`SMC_IRQ_W{1'b0}};
			state_q <= ST_IDLE;
			cnt_q <= {CNT_W{1'b0}};
			protected_q <= 1'b0;
			bemf_seen_q <= 1'b0;
			status_q <= 3'h0;
		end else begin
			if (wr & is_addr(PADDR, `SMC_REG_CTRL))
				ctrl_q <= PWDATA[3:0];
			if (wr & is_addr(PADDR, `SMC_REG_IRQ_MASK))
				irq_mask_q <= PWDATA[`SMC_IRQ_W-1:0];
			if (frame_wr)
				frame_q <= fr;
			frame_go_q <= frame_addressed;
			// set wins over clear
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
			state_q <= state_d;
			cnt_q <= cnt_d;
			protected_q <= protected_d;
			// back-emf held until reported in a return field
			if (bemf_pulse)
				bemf_seen_q <= 1'b1;
			else if (frame_go_q)
				bemf_seen_q <= 1'b0;
			status_q <= code;
		end
	end

	// outputs straight from flops
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			BRIDGE_GATES <= 4'h0;
			CELL_ENERGISE <= 1'b0;
			RETURN_STATUS <= 3'h0;
			RETURN_VALID <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~rd_ok;
			PRDATA <= 32'h0;
			if (PSEL & ~PENABLE & ~PWRITE) begin
				if (is_addr(PADDR, `SMC_REG_CTRL))
					PRDATA <= {28'h0, ctrl_q};
				else if (is_addr(PADDR, `SMC_REG_FRAME))
					PRDATA <= {24'h0, frame_q};
				else if (is_addr(PADDR, `SMC_REG_STATUS))
					PRDATA <= {24'h0, protected_q, pull_window, state_q, 1'b0, status_q};
				else if (is_addr(PADDR, `SMC_REG_IRQ_STAT))
					PRDATA <= {28'h0, irq_stat_q};
				else if (is_addr(PADDR, `SMC_REG_IRQ_MASK))
					PRDATA <= {28'h0, irq_mask_q};
				else if (is_addr(PADDR, `SMC_REG_BRIDGE))
					PRDATA <= {28'h0, gates};
				else if (is_addr(PADDR, `SMC_REG_ADDR))
					PRDATA <= {29'h0, SLAVE_SEL};
			end
			BRIDGE_GATES <= gates;
			CELL_ENERGISE <= (state_q == ST_ENERGISE) & (cnt_q < SPAN_CYC);
			if (frame_go_q) begin
				// live code, so the frame that starts energising already reports it
				RETURN_STATUS <= code;
				RETURN_VALID <= 1'b1;
			end else begin
				RETURN_VALID <= 1'b0;
			end
			IRQ <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule // smc_top

/* bench/smc_props.sv */
// port checker for the stepper slave block
`timescale 1ns/1ps
module smc_props #(parameter [2:0] SLAVE_SEL = 3'h0) (
	// clock and reset
	input wire CLK,
	input wire RST,
	// apb
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire PREADY,
	input wire PSLVERR,
	// pins
	input wire PROG_LEVEL,
	input wire CELL_ENERGISE,
	input wire [2:0] RETURN_STATUS,
	input wire RETURN_VALID
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence frame_to_me;
		PSEL && PENABLE && PWRITE && PADDR == 8'h04 && PWDATA[7:5] == SLAVE_SEL;
	endsequence
	sequence answer;
		##2 RETURN_VALID;
	endsequence
	a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
	a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("stray error");
	a_frame_answer: assert property (frame_to_me |-> answer) else $error("no return");
	a_return_once: assert property (RETURN_VALID |=> !RETURN_VALID) else $error("long pulse");
	a_code_known: assert property (RETURN_VALID |-> RETURN_STATUS inside {3'h0, 3'h1, 3'h2,
		3'h4, 3'h6}) else $error("bad code");
	a_active_code: assert property (CELL_ENERGISE && RETURN_VALID |-> RETURN_STATUS == 3'h6)
		else $error("not 110");
	a_level_drop: assert property (CELL_ENERGISE && !PROG_LEVEL |-> ##[1:4] !CELL_ENERGISE)
		else $error("no abort");
	a_energise_min: assert property ($rose(CELL_ENERGISE) |=> CELL_ENERGISE [*8])
		else $error("short energise");
endmodule // smc_props

/* bench/smc_master.sv */
// bus master model: programming level and matching code count
`timescale 1ns/1ps
module smc_master (
	// clock and reset
	input wire clk,
	input wire rst,
	// bench request
	input wire prog_req,
	// return field
	input wire ret_valid,
	input wire [2:0] ret_code,
	// outputs
	output reg prog_level_q,
	output reg [3:0] match_q
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_level_q <= 1'b0;
			match_q <= 4'h0;
		end else begin
			prog_level_q <= prog_req;
			if (ret_valid)
				match_q <= (ret_code == 3'h6 || ret_code == 3'h4) ? match_q + 4'h1 : 4'h0;
		end
	end
endmodule // smc_master

/* bench/tb_stepper_slave_protect_prog_and_drive.sv */
// self-checking bench for the stepper slave block
`timescale 1ns/1ps
`include "smc_consts.vh"
module tb_stepper_slave_protect_prog_and_drive;
	logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, prog_req = 1'b0;
	logic SENSE_HI = 1'b0, SENSE_LO = 1'b0, PREADY, PSLVERR, CELL_ENERGISE, RETURN_VALID, IRQ;
	logic PROG_LEVEL, irq_a, err;
	logic [7:0] PADDR = 8'h0;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd, lfsr = 32'hd607;
	logic [3:0] BRIDGE_GATES, match;
	logic [2:0] RETURN_STATUS, exp_q[$];
	logic [3:0] ctl[4] = '{4'h6, 4'h7, 4'h4, 4'h2}, gexp[4] = '{4'ha, 4'h5, 4'h0, 4'h2};
	int err_total = 0, tests_run = 0, i, hi_cnt = 0;
	always #5 CLK = ~CLK;
	smc_top smc_top_inst (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PROG_LEVEL(PROG_LEVEL), .SENSE_HI(SENSE_HI), .SENSE_LO(SENSE_LO), .IRQ(IRQ),
		.BRIDGE_GATES(BRIDGE_GATES), .CELL_ENERGISE(CELL_ENERGISE),
		.RETURN_STATUS(RETURN_STATUS), .RETURN_VALID(RETURN_VALID));
	smc_master smc_master_inst (.clk(CLK), .rst(RST), .prog_req(prog_req),
		.ret_valid(RETURN_VALID), .ret_code(RETURN_STATUS), .prog_level_q(PROG_LEVEL),
		.match_q(match));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] e);
		tests_run++;
		if (seen !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", w, e, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one edge first so back-to-back calls never drive twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rdk(input string w, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(w, rd, e);
	endtask
	task automatic frm(input logic [4:0] d, input logic [2:0] code);
		exp_q.push_back(code);
		apb(1'b1, `SMC_REG_FRAME, {24'h0, 3'h0, d});
	endtask
	always @(negedge CLK) begin
		if (CELL_ENERGISE === 1'b1)
			hi_cnt++;
		if (RETURN_VALID === 1'b1)
			chk("return code", RETURN_STATUS, exp_q.size() ? exp_q.pop_front() : 3'h7);
	end
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		rdk("irq stat", `SMC_REG_IRQ_STAT, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `SMC_REG_CTRL, {28'h0, ctl[i]});
			rdk("gates", `SMC_REG_BRIDGE, {28'h0, gexp[i]});
			chk("gate pins", BRIDGE_GATES, gexp[i]);
			lfsr = nxt(lfsr);
			apb(1'b1, `SMC_REG_FRAME, {24'h0, 3'h1 + lfsr[2:0] % 3'h7, lfsr[7:3]});
		end
		frm(5'h03, 3'h0);
		for (i = 0; i < 2; i++) begin
			@(posedge CLK);
			{SENSE_HI, SENSE_LO} <= i ? 2'b01 : 2'b10;
			repeat (3) @(posedge CLK);
			{SENSE_HI, SENSE_LO} <= 2'b00;
			repeat (4) @(posedge CLK);
			frm(5'h03, 3'h1);
			frm(5'h03, 3'h0);
		end
		rdk("bemf stat", `SMC_REG_IRQ_STAT, 32'h4);
		apb(1'b1, `SMC_REG_IRQ_MASK, 32'h0);
		repeat (3) @(posedge CLK);
		irq_a = IRQ;
		apb(1'b1, `SMC_REG_IRQ_MASK, 32'hf);
		repeat (3) @(posedge CLK);
		chk("irq masking", {31'h0, IRQ}, {31'h0, ~irq_a});
		apb(1'b1, `SMC_REG_IRQ_STAT, 32'hf);
		repeat (3) @(posedge CLK);
		chk("irq cleared", {31'h0, IRQ}, 32'h0);
		prog_req <= 1'b1;
		repeat (4) @(posedge CLK);
		frm(5'h10, 3'h0);
		frm(5'h10, 3'h6);
		prog_req <= 1'b0;
		repeat (6) @(posedge CLK);
		chk("abort", {31'h0, CELL_ENERGISE}, 32'h0);
		frm(5'h03, 3'h0);
		prog_req <= 1'b1;
		repeat (4) @(posedge CLK);
		frm(5'h10, 3'h0);
		repeat (27500) @(posedge CLK);
		hi_cnt = 0;
		frm(5'h10, 3'h6);
		repeat (5000) @(posedge CLK);
		frm(5'h03, 3'h6);
		while (CELL_ENERGISE !== 1'b0)
			@(posedge CLK);
		chk("energise cycles", hi_cnt, 32'd50000);
		frm(5'h03, 3'h4);
		frm(5'h03, 3'h4);
		repeat (4) @(posedge CLK);
		chk("matches", {28'h0, match}, 32'h4);
		chk("pending", exp_q.size(), 32'h0);
		tally_and_finish();
	end
endmodule // tb_stepper_slave_protect_prog_and_drive
bind smc_top smc_props #(.SLAVE_SEL(SLAVE_SEL)) smc_props_inst (.CLK(CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .PROG_LEVEL(PROG_LEVEL),
	.CELL_ENERGISE(CELL_ENERGISE), .RETURN_STATUS(RETURN_STATUS), .RETURN_VALID(RETURN_VALID));
